// ### design/interval_timer_pkg.sv
// Package with register map, field positions and reset values of the interval timer
package interval_timer_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  // Register word offsets
  localparam logic [2:0] OFF_TIMER_FLAGS   = 3'h0;
  localparam logic [2:0] OFF_TIMER_CONTROL = 3'h1;
  localparam logic [2:0] OFF_RELOAD_LOW    = 3'h2;
  localparam logic [2:0] OFF_RELOAD_HIGH   = 3'h3;
  localparam logic [2:0] OFF_CAPTURE_LOW   = 3'h4;
  localparam logic [2:0] OFF_CAPTURE_HIGH  = 3'h5;

  // Flag register fields
  localparam int BIT_EXPIRED_FLAG = 0;
  localparam int BIT_RUNNING      = 1;

  // Control register fields
  localparam int BIT_EXPIRY_IRQ_ENABLE = 0;
  localparam int BIT_REPEAT_MODE       = 1;
  localparam int BIT_START             = 2;
  localparam int BIT_STOP              = 3;

  // Default timeout period minus one, in clocks
  localparam logic [31:0] RESET_PERIOD = 32'h0000_FFFF;
  localparam logic [31:0] COUNT_ZERO   = 32'h0000_0000;
  localparam logic [15:0] READ_ZERO    = 16'h0000;

endpackage

// ### design/timer_bus_if.sv
// Interface carrying decoded register write strobes between top and decoder
`timescale 1ns/1ps
interface timer_bus_if;
  logic        wr_flags;
  logic        wr_control;
  logic        wr_reload_low;
  logic        wr_reload_high;
  logic        wr_capture;
  logic        rd_sel_valid;

  modport decoder
  (
    output wr_flags,
    output wr_control,
    output wr_reload_low,
    output wr_reload_high,
    output wr_capture,
    output rd_sel_valid
  );
  modport core
  (
    input  wr_flags,
    input  wr_control,
    input  wr_reload_low,
    input  wr_reload_high,
    input  wr_capture,
    input  rd_sel_valid
  );
endinterface

// ### design/timer_write_decode.sv
// Address decoder turning bus writes into one-cycle register strobes
`timescale 1ns/1ps
module timer_write_decode
(
  input  wire logic       chip_select,
  input  wire logic       write,
  input  wire logic [2:0] address,
  timer_bus_if.decoder    strobes
);

  // Write strobes per register; both capture offsets share one strobe
  always_comb
  begin
    strobes.wr_flags       = chip_select && write && (address == interval_timer_pkg::OFF_TIMER_FLAGS);
    strobes.wr_control     = chip_select && write && (address == interval_timer_pkg::OFF_TIMER_CONTROL);
    strobes.wr_reload_low  = chip_select && write && (address == interval_timer_pkg::OFF_RELOAD_LOW);
    strobes.wr_reload_high = chip_select && write && (address == interval_timer_pkg::OFF_RELOAD_HIGH);
    strobes.wr_capture     = chip_select && write &&
                             ((address == interval_timer_pkg::OFF_CAPTURE_LOW) ||
                              (address == interval_timer_pkg::OFF_CAPTURE_HIGH));
    strobes.rd_sel_valid   = (address <= interval_timer_pkg::OFF_CAPTURE_HIGH);
  end

endmodule

// ### design/interval_timer_watchdog.sv
// Top module of the 32-bit down-counting interval timer with optional watchdog
// Notes on behaviour
// - Expiry flag sets when the counter reaches zero and stays until cleared.
// - Writing zero to the flag register clears the expiry flag.
// - Running bit reads 1 while counting; flag register writes never touch it.
// - Interrupt request follows expiry flag only while interrupt enable is set.
// - Repeat mode keeps counting through zero; otherwise counter reloads and stops at zero, except in watchdog or free-running builds.
// - On reaching zero the counter reloads from the 32-bit period pair.
// - Start bit resumes a stopped counter from its current value.
// - Stop bit halts the counter unless start/stop controls are omitted or the build is a watchdog.
// - Period minus one: low half at offset 2, high half at offset 3.
// - Counter loads from the period on period writes and on reaching zero.
// - Counter holds zero one clock, so the period is stored value plus one.
// - Period writes stop the counter unless start/stop controls are omitted or the build is a watchdog.
// - With a fixed period, period writes reset the counter to that period.
// - Any capture write copies the whole counter into both capture registers.
// - Optional expiry strobe is high exactly one clock per zero reach.
// - Watchdog build: starts stopped, cannot stop, pulses reset request at zero.
// - Build-time period gives the reset value of both period registers.
// - Without start/stop controls the timer runs from reset without software, except in the watchdog build.
`timescale 1ns/1ps
module interval_timer_watchdog
#(
  parameter logic [31:0] TIMEOUT_PERIOD  = interval_timer_pkg::RESET_PERIOD,
  parameter bit          WRITABLE_PERIOD = 1'b1,
  parameter bit          HAS_CAPTURE     = 1'b1,
  parameter bit          HAS_START_STOP  = 1'b1,
  parameter bit          HAS_PULSE       = 1'b1,
  parameter bit          WATCHDOG        = 1'b0
)
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        chip_select,
  input  wire logic        write,
  input  wire logic        read,
  input  wire logic [2:0]  address,
  input  wire logic [15:0] write_data,
  output logic      [15:0] read_data,
  output logic             irq,
  output logic             expiry_pulse,
  output logic             reset_request
);

  timer_bus_if strobes ();

  logic [31:0] counter;
  logic [31:0] period;
  logic [31:0] capture;
  logic        running;
  logic        expired_flag;
  logic        expiry_irq_enable;
  logic        repeat_mode;
  logic        at_zero;
  logic        start_req;
  logic        stop_req;
  logic        period_wr;
  logic        can_stop;
  logic [31:0] reload_value;
  logic [15:0] next_read_data;

  timer_write_decode u_decode
  (
    .chip_select (chip_select),
    .write       (write),
    .address     (address),
    .strobes     (strobes)
  );

  // Decoded controls; watchdog and free-running builds cannot be stopped
  always_comb
  begin
    at_zero      = running && (counter == interval_timer_pkg::COUNT_ZERO);
    can_stop     = HAS_START_STOP && !WATCHDOG;
    start_req    = strobes.wr_control && write_data[interval_timer_pkg::BIT_START] &&
                   (HAS_START_STOP || WATCHDOG);
    stop_req     = strobes.wr_control && write_data[interval_timer_pkg::BIT_STOP] && can_stop;
    period_wr    = strobes.wr_reload_low || strobes.wr_reload_high;
    reload_value = WRITABLE_PERIOD ? period : TIMEOUT_PERIOD;
  end

  // Period registers, reset to the build-time period
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      period <= TIMEOUT_PERIOD;
    end
    else if (WRITABLE_PERIOD)
    begin
      if (strobes.wr_reload_low)
      begin
        period[15:0] <= write_data;
      end
      if (strobes.wr_reload_high)
      begin
        period[31:16] <= write_data;
      end
    end
  end

  // Load value uses the freshly written half so a period write takes effect at once
  logic [31:0] load_value;
  always_comb
  begin
    load_value = reload_value;
    if (WRITABLE_PERIOD && strobes.wr_reload_low)
    begin
      load_value[15:0] = write_data;
    end
    if (WRITABLE_PERIOD && strobes.wr_reload_high)
    begin
      load_value[31:16] = write_data;
    end
  end

  // Down counter: holds zero for one clock, then reloads
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      counter <= TIMEOUT_PERIOD;
    end
    else if (period_wr)
    begin
      counter <= load_value;
    end
    else if (at_zero)
    begin
      counter <= reload_value;
    end
    else if (running)
    begin
      counter <= counter - 32'h0000_0001;
    end
  end

  // Run state; a stop wins over a start that arrives in the same write
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      running <= !HAS_START_STOP && !WATCHDOG;
    end
    else if (stop_req || (period_wr && can_stop))
    begin
      running <= 1'b0;
    end
    else if (start_req)
    begin
      running <= 1'b1;
    end
    else if (at_zero && !repeat_mode && can_stop)
    begin
      running <= 1'b0;
    end
  end

  // Control register bits held by software
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      expiry_irq_enable <= 1'b0;
      repeat_mode       <= 1'b0;
    end
    else if (strobes.wr_control)
    begin
      expiry_irq_enable <= write_data[interval_timer_pkg::BIT_EXPIRY_IRQ_ENABLE];
      repeat_mode       <= write_data[interval_timer_pkg::BIT_REPEAT_MODE];
    end
  end

  // Sticky expiry flag; a zero reach in the clearing cycle wins
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      expired_flag <= 1'b0;
    end
    else if (at_zero)
    begin
      expired_flag <= 1'b1;
    end
    else if (strobes.wr_flags && (write_data == interval_timer_pkg::READ_ZERO))
    begin
      expired_flag <= 1'b0;
    end
  end

  // Snapshot of the counter; counting goes on undisturbed
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      capture <= interval_timer_pkg::COUNT_ZERO;
    end
    else if (HAS_CAPTURE && strobes.wr_capture)
    begin
      capture <= counter;
    end
  end

  // Interrupt, expiry strobe and reset request, all registered
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      irq           <= 1'b0;
      expiry_pulse  <= 1'b0;
      reset_request <= 1'b0;
    end
    else
    begin
      irq           <= expiry_irq_enable && (expired_flag || at_zero);
      expiry_pulse  <= HAS_PULSE && at_zero;
      reset_request <= WATCHDOG && at_zero;
    end
  end

  // Read multiplexer; reserved bits and unmapped offsets read zero
  always_comb
  begin
    next_read_data = interval_timer_pkg::READ_ZERO;
    case (address)
      interval_timer_pkg::OFF_TIMER_FLAGS:
      begin
        next_read_data[interval_timer_pkg::BIT_EXPIRED_FLAG] = expired_flag;
        next_read_data[interval_timer_pkg::BIT_RUNNING]      = running;
      end
      interval_timer_pkg::OFF_TIMER_CONTROL:
      begin
        next_read_data[interval_timer_pkg::BIT_EXPIRY_IRQ_ENABLE] = expiry_irq_enable;
        next_read_data[interval_timer_pkg::BIT_REPEAT_MODE]       = repeat_mode;
      end
      interval_timer_pkg::OFF_RELOAD_LOW:   next_read_data = reload_value[15:0];
      interval_timer_pkg::OFF_RELOAD_HIGH:  next_read_data = reload_value[31:16];
      interval_timer_pkg::OFF_CAPTURE_LOW:  next_read_data = capture[15:0];
      interval_timer_pkg::OFF_CAPTURE_HIGH: next_read_data = capture[31:16];
      default:                              next_read_data = interval_timer_pkg::READ_ZERO;
    endcase
    if (!strobes.rd_sel_valid)
    begin
      next_read_data = interval_timer_pkg::READ_ZERO;
    end
  end

  // Read data registered: one clock of latency after a read is taken
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      read_data <= interval_timer_pkg::READ_ZERO;
    end
    else if (chip_select && read)
    begin
      read_data <= next_read_data;
    end
  end

endmodule

// ### tb/timer_chk.sv
// Checker on the interval timer top ports
`timescale 1ns/1ps
module timer_chk
(
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        chip_select,
  input wire logic        write,
  input wire logic        read,
  input wire logic [2:0]  address,
  input wire logic [15:0] write_data,
  input wire logic [15:0] read_data,
  input wire logic        irq,
  input wire logic        expiry_pulse,
  input wire logic        reset_request
);
  logic [1:0] ctl_q;
  // Mirror of enable and repeat bits, since the core hides them
  always_ff @(posedge sys_clk)
    if (sys_rst)
      ctl_q <= 2'h0;
    else if (chip_select && write && address == 3'h1)
      ctl_q <= write_data[1:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_pulse_single: assert property (expiry_pulse |=> !expiry_pulse) else $error("pulse too wide");
  a_irq_enabled: assert property (irq |-> $past(ctl_q[0])) else $error("irq while masked");
  a_pulse_irq: assert property (expiry_pulse && $past(ctl_q[0]) |-> irq) else $error("irq missing");
  a_irq_sticky: assert property (irq && !$past(chip_select && write && address < 3'h2) |=> irq)
    else $error("irq dropped");
  a_no_reset_req: assert property (!reset_request) else $error("reset request");
  a_read_hold: assert property (!(chip_select && read) |=> $stable(read_data)) else $error("read moved");
  a_unmapped_zero: assert property (chip_select && read && address > 3'h5 |=> read_data == 16'h0000)
    else $error("unmapped read");
  a_ctl_read: assert property (chip_select && read && address == 3'h1 |=> read_data == {14'h0000, $past(ctl_q)})
    else $error("control read");
  c_pulse: cover property (expiry_pulse);
  c_irq: cover property (irq ##1 irq);
  c_snap: cover property (chip_select && write && address == 3'h4);
endmodule
bind interval_timer_watchdog timer_chk u_timer_chk
(
  .sys_clk(sys_clk), .sys_rst(sys_rst), .chip_select(chip_select), .write(write), .read(read),
  .address(address), .write_data(write_data), .read_data(read_data), .irq(irq),
  .expiry_pulse(expiry_pulse), .reset_request(reset_request)
);

// ### tb/host_bus.sv
// Bus master model issuing register reads and writes
`timescale 1ns/1ps
module host_bus
(
  input  wire logic        sys_clk,
  input  wire logic [15:0] read_data,
  output logic             chip_select,
  output logic             write,
  output logic             read,
  output logic [2:0]       address,
  output logic [15:0]      write_data
);
  // Idle bus from time zero
  initial
  begin
    chip_select = 1'h0;
    write       = 1'h0;
    read        = 1'h0;
    address     = 3'h0;
    write_data  = 16'h0000;
  end
  // One write; released lines show the inverse so stale data never looks valid
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    chip_select <= 1'h1;
    write       <= 1'h1;
    address     <= a;
    write_data  <= d;
    @(posedge sys_clk);
    chip_select <= 1'h0;
    write       <= 1'h0;
    address     <= ~a;
    write_data  <= ~d;
  endtask
  // One read; data is registered at the taking edge and taken once settled mid-cycle
  task rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    chip_select <= 1'h1;
    read        <= 1'h1;
    address     <= a;
    @(posedge sys_clk);
    chip_select <= 1'h0;
    read        <= 1'h0;
    address     <= ~a;
    @(negedge sys_clk);
    d = read_data;
  endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the interval timer with a reference model
`timescale 1ns/1ps
module tb;
  logic        sys_clk;
  logic        sys_rst;
  logic        chip_select;
  logic        write;
  logic        read;
  logic [2:0]  address;
  logic [15:0] write_data;
  logic [15:0] read_data;
  logic        irq;
  logic        expiry_pulse;
  logic        reset_request;
  logic [31:0] cnt, per, snap, c0;
  logic [15:0] erd;
  logic        run, flg, ien, rep, zr, m_irq, m_pul;
  int          n_fail, n_tests, k, p;
  // Short period keeps the run brief
  interval_timer_watchdog #(.TIMEOUT_PERIOD(32'h0000_0005)) u_interval_timer_watchdog
  (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .chip_select(chip_select), .write(write), .read(read),
    .address(address), .write_data(write_data), .read_data(read_data), .irq(irq),
    .expiry_pulse(expiry_pulse), .reset_request(reset_request)
  );
  host_bus u_host_bus
  (
    .sys_clk(sys_clk), .read_data(read_data), .chip_select(chip_select), .write(write),
    .read(read), .address(address), .write_data(write_data)
  );
  always #12.5 sys_clk = ~sys_clk;
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task rd_chk(input logic [2:0] a);
    logic [15:0] d;
    u_host_bus.rd(a, d);
    chk("read_data", d, erd);
  endtask
  // Bounded wait; k is the clock count up to the pulse
  task wait_pulse;
    for (k = 1; k <= 64; k++)
    begin
      @(negedge sys_clk);
      if (expiry_pulse === 1'h1)
        return;
    end
    n_fail++;
    $display("[ERR] expiry_pulse expected 1 seen 0");
    close_out;
  endtask
  // Reference model, stepped on the edges the design samples
  always @(posedge sys_clk)
  begin
    c0 = cnt;
    zr = run && cnt == 32'h0000_0000;
    if (sys_rst)
      {cnt, per, snap, run, flg, ien, rep, m_irq, m_pul, erd} = {32'h5, 32'h5, 38'h0, 16'h0};
    else
    begin
      m_irq = ien && (flg || zr);
      m_pul = zr;
      if (chip_select && read)
        case (address)
          3'h0: erd = {14'h0000, run, flg};
          3'h1: erd = {14'h0000, rep, ien};
          3'h2: erd = per[15:0];
          3'h3: erd = per[31:16];
          3'h4: erd = snap[15:0];
          3'h5: erd = snap[31:16];
          default: erd = 16'h0000;
        endcase
      // Reload at zero; one-shot drops running at the same edge
      if (zr)
        {cnt, flg, run} = {per, 1'h1, rep};
      else if (run)
        cnt = cnt - 32'h1;
      if (chip_select && write)
        case (address)
          3'h0: if (write_data == 16'h0000 && !zr) flg = 1'h0;
          3'h1: {run, rep, ien} = {write_data[3] ? 1'h0 : (write_data[2] | run), write_data[1:0]};
          3'h2: {per[15:0], cnt, run} = {write_data, per[31:16], write_data, 1'h0};
          3'h3: {per[31:16], cnt, run} = {write_data, write_data, per[15:0], 1'h0};
          3'h4, 3'h5: snap = c0;
          default: ;
        endcase
    end
  end
  always @(negedge sys_clk)
    if (!sys_rst)
    begin
      chk("irq", {15'h0000, irq}, {15'h0000, m_irq});
      chk("expiry_pulse", {15'h0000, expiry_pulse}, {15'h0000, m_pul});
      chk("reset_request", {15'h0000, reset_request}, 16'h0000);
    end
  initial
  begin
    {sys_clk, sys_rst, n_fail, n_tests} = {2'h1, 64'h0};
    sys_clk = 1'h0;
    p = $urandom(43);
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'h0;
    for (int i = 0; i < 8; i++)
      rd_chk(3'(i));
    $display("test reset values done");
    // One-shot with interrupt; start and stop never set together
    u_host_bus.wr(3'h1, 16'h0005);
    wait_pulse;
    repeat (3) @(posedge sys_clk);
    rd_chk(3'h0);
    u_host_bus.wr(3'h0, 16'h0002);
    rd_chk(3'h0);
    u_host_bus.wr(3'h0, 16'h0000);
    rd_chk(3'h0);
    $display("test one-shot done");
    p = 3 + $urandom % 5;
    u_host_bus.wr(3'h2, 16'(p));
    u_host_bus.wr(3'h3, 16'h0000);
    for (int i = 0; i < 4; i++)
      rd_chk(3'(i));
    u_host_bus.wr(3'h1, 16'h0007);
    wait_pulse;
    wait_pulse;
    chk("period", 16'(k), 16'(p + 1));
    u_host_bus.wr(3'h4, 16'($urandom));
    rd_chk(3'h4);
    rd_chk(3'h5);
    u_host_bus.wr(3'h1, 16'h000B);
    repeat (4) @(posedge sys_clk);
    u_host_bus.wr(3'h5, 16'($urandom));
    rd_chk(3'h4);
    $display("test repeat and stop done");
    // Masked interrupt keeps irq low while expiries continue
    u_host_bus.wr(3'h1, 16'h0006);
    u_host_bus.wr(3'h0, 16'h0000);
    wait_pulse;
    u_host_bus.wr(3'h6, 16'hFFFF);
    rd_chk(3'h6);
    rd_chk(3'h0);
    $display("test mask and unmapped done");
    close_out;
  end
endmodule
